// ==== timer_a_ctrl.sv ====
// Contract
// - auto-lock write sets lock until enabled buffers valid
// - after clear, update transfers then relocks
// - without auto-lock, only software moves lock
// - mode field picks sequence, top, update, overflow
// - normal, frequency, single-slope top and events
// - dual-slope overflow at top, both, bottom
// - normal mode makes no waveform
// - waveform reaches pin only when channel enabled
// - disabled timer: override bits set output levels
// - split mode runs two 8-bit counters
// - clear view: one clears lock or direction
// - set view: one sets lock or direction
// - both views read the same bits
// - command field acts on write, reads zero
// - commands none, update, restart, hard reset
// - hard reset command ignored while enabled
// - lock blocks buffer copy on update
// - direction up at 0, down at 1
// - buffer valid set on write, cleared on update
// - enabled channel overrides port output; code does so only in frequency and slope modes, never in normal or split mode
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "timer_a_defines.svh"

module timer_a_ctrl #(
  parameter int NCH = 3,
  parameter logic [`TA_CNT_W-1:0] PERIOD_RESET = '1
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_clk_en,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic [NCH-1:0] o_wave_out,
  output logic [NCH-1:0] o_wave_override,
  output logic o_overflow,
  output logic o_update_lock,
  output logic o_count_down
);

  localparam int CW = `TA_CNT_W;
  localparam int HW = CW / 2;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    return a == ofs;
  endfunction

  function automatic timer_a_pkg::wave_class_e wave_class(input logic [2:0] m);
    case (m)
      `TA_WM_FREQ: return timer_a_pkg::wc_freq;
      `TA_WM_SINGLE: return timer_a_pkg::wc_single;
      `TA_WM_DS_TOP, `TA_WM_DS_BOTH, `TA_WM_DS_BOTTOM: return timer_a_pkg::wc_dual;
      default: return timer_a_pkg::wc_none;
    endcase
  endfunction

  logic enable;
  logic auto_lock;
  logic split;
  logic update_lock;
  logic count_down;
  logic [2:0] wave_mode;
  logic [NCH-1:0] chan_en;
  logic [NCH-1:0] ovr_val;
  logic [NCH-1:0] wave_level;
  logic [CW-1:0] cnt;
  logic [CW-1:0] top;
  logic [CW-1:0] buf_val [0:NCH];
  logic [CW-1:0] live [0:NCH];
  logic [NCH:0] buf_valid;
  timer_a_pkg::wave_class_e cls;
  timer_a_pkg::soft_cmd_e cmd;
  logic wr_clr;
  logic wr_set;
  logic cmd_wr;
  logic auto_lock_wr;
  logic force_restart;
  logic force_reset;
  logic run;
  logic at_top;
  logic at_bottom;
  logic hw_update;
  logic do_update;
  logic overflow_evt;
  logic all_bv;
  logic [7:0] next_rdata;

  // ****************************************
  // decode
  // ****************************************
  assign wr_clr = i_wr && hit(i_addr, `TA_OFS_CLR);
  assign wr_set = i_wr && hit(i_addr, `TA_OFS_SET);
  assign cmd_wr = wr_clr || wr_set;
  assign cmd = timer_a_pkg::soft_cmd_e'(i_wdata[`TA_CMD_MSB:`TA_CMD_LSB]);
  assign auto_lock_wr = i_wr && hit(i_addr, `TA_OFS_WAVE) && i_wdata[`TA_BIT_AUTO_LOCK];
  assign force_restart = cmd_wr && cmd == timer_a_pkg::cmd_restart;
  assign force_reset = cmd_wr && cmd == timer_a_pkg::cmd_hard_reset && !enable;
  assign cls = wave_class(wave_mode);
  assign run = enable && !split;
  assign top = (wave_mode == `TA_WM_FREQ) ? live[1] : live[0];
  assign at_top = cnt == top;
  assign at_bottom = cnt == '0;
  // single and dual slope update at bottom, the rest at top
  assign hw_update = run && ((cls == timer_a_pkg::wc_single || cls == timer_a_pkg::wc_dual) ?
                     at_bottom : at_top);
  assign do_update = (hw_update || (cmd_wr && cmd == timer_a_pkg::cmd_update)) && !update_lock;
  assign all_bv = &(buf_valid[NCH:1] | ~chan_en);

  always_comb begin
    case (wave_mode)
      `TA_WM_SINGLE, `TA_WM_DS_BOTTOM: overflow_evt = run && at_bottom;
      `TA_WM_DS_BOTH: overflow_evt = run && (at_top || at_bottom);
      default: overflow_evt = run && at_top;
    endcase
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      enable <= 1'b0;
      chan_en <= '0;
      auto_lock <= 1'b0;
      wave_mode <= `TA_WM_NORMAL;
      ovr_val <= '0;
      split <= 1'b0;
    end else if (i_clk_en) begin
      if (i_wr && hit(i_addr, `TA_OFS_ENABLE)) begin
        enable <= i_wdata[`TA_BIT_EN];
      end
      if (i_wr && hit(i_addr, `TA_OFS_WAVE)) begin
        chan_en <= i_wdata[`TA_CHEN_LSB +: NCH];
        auto_lock <= i_wdata[`TA_BIT_AUTO_LOCK];
        wave_mode <= i_wdata[`TA_MODE_MSB:0];
      end
      if (i_wr && hit(i_addr, `TA_OFS_OVR)) begin
        ovr_val <= i_wdata[NCH-1:0];
      end
      if (i_wr && hit(i_addr, `TA_OFS_SPLIT)) begin
        split <= i_wdata[`TA_BIT_SPLIT];
      end
      if (force_reset) begin
        chan_en <= '0;
        auto_lock <= 1'b0;
        wave_mode <= `TA_WM_NORMAL;
        ovr_val <= '0;
        split <= 1'b0;
      end
    end
  end

  // ****************************************
  // update lock
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      update_lock <= 1'b0;
    end else if (i_clk_en) begin
      if (force_reset) begin
        update_lock <= 1'b0;
      end else if (wr_clr && i_wdata[`TA_BIT_LOCK]) begin
        update_lock <= 1'b0;
      end else if (wr_set && i_wdata[`TA_BIT_LOCK]) begin
        update_lock <= 1'b1;
      end else if (auto_lock_wr) begin
        update_lock <= 1'b1;
      end else if (auto_lock && do_update) begin
        update_lock <= 1'b1;
      end else if (auto_lock && update_lock && all_bv) begin
        update_lock <= 1'b0;
      end
    end
  end

  // ****************************************
  // direction
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      count_down <= 1'b0;
    end else if (i_clk_en) begin
      if (force_reset || force_restart) begin
        count_down <= 1'b0;
      end else if (wr_clr && i_wdata[`TA_BIT_DIR]) begin
        count_down <= 1'b0;
      end else if (wr_set && i_wdata[`TA_BIT_DIR]) begin
        count_down <= 1'b1;
      end else if (run && cls == timer_a_pkg::wc_dual) begin
        if (!count_down && at_top) begin
          count_down <= 1'b1;
        end else if (count_down && at_bottom) begin
          count_down <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // counter
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cnt <= '0;
    end else if (i_clk_en) begin
      if (force_reset || force_restart) begin
        cnt <= '0;
      end else if (enable && split) begin
        // two independent byte counters, each reloading from its period byte
        cnt[HW-1:0] <= (cnt[HW-1:0] == '0) ? live[0][HW-1:0] : cnt[HW-1:0] - 1'b1;
        cnt[CW-1:HW] <= (cnt[CW-1:HW] == '0) ? live[0][CW-1:HW] : cnt[CW-1:HW] - 1'b1;
      end else if (run) begin
        if (!count_down) begin
          if (at_top) begin
            cnt <= (cls == timer_a_pkg::wc_dual) ? cnt - 1'b1 : '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end else begin
          if (at_bottom) begin
            cnt <= (cls == timer_a_pkg::wc_dual) ? cnt + 1'b1 : top;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // period and compare buffers, index 0 is period
  // ****************************************
  for (genvar g = 0; g <= NCH; g++) begin : g_buf
    logic wr_lo;
    logic wr_hi;
    assign wr_lo = i_wr && hit(i_addr, `TA_OFS_BUF + 6'(2 * g));
    assign wr_hi = i_wr && hit(i_addr, `TA_OFS_BUF + 6'(2 * g + 1));
    always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
        buf_val[g] <= (g == 0) ? PERIOD_RESET : '0;
        live[g] <= (g == 0) ? PERIOD_RESET : '0;
        buf_valid[g] <= 1'b0;
      end else if (i_clk_en) begin
        if (force_reset) begin
          buf_val[g] <= (g == 0) ? PERIOD_RESET : '0;
          live[g] <= (g == 0) ? PERIOD_RESET : '0;
          buf_valid[g] <= 1'b0;
        end else begin
          if (wr_lo) begin
            buf_val[g][HW-1:0] <= i_wdata;
          end
          if (wr_hi) begin
            buf_val[g][CW-1:HW] <= i_wdata;
          end
          if (do_update && buf_valid[g]) begin
            live[g] <= buf_val[g];
          end
          // a buffer write in the update cycle keeps its valid bit
          if (wr_lo || wr_hi) begin
            buf_valid[g] <= 1'b1;
          end else if (do_update) begin
            buf_valid[g] <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************
  // waveform generator
  // ****************************************
  for (genvar g = 0; g < NCH; g++) begin : g_wave
    logic match;
    assign match = cnt == live[g + 1];
    always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
        wave_level[g] <= 1'b0;
      end else if (i_clk_en) begin
        if (force_reset) begin
          wave_level[g] <= 1'b0;
        end else if (!enable) begin
          if (i_wr && hit(i_addr, `TA_OFS_OVR)) begin
            wave_level[g] <= i_wdata[g];
          end
        end else if (!split) begin
          case (cls)
            timer_a_pkg::wc_freq: begin
              if (match) begin
                wave_level[g] <= ~wave_level[g];
              end
            end
            timer_a_pkg::wc_single: begin
              if (at_bottom) begin
                wave_level[g] <= 1'b1;
              end else if (match) begin
                wave_level[g] <= 1'b0;
              end
            end
            timer_a_pkg::wc_dual: begin
              if (match) begin
                wave_level[g] <= count_down;
              end
            end
            default: begin
              wave_level[g] <= wave_level[g];
            end
          endcase
        end
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_overflow <= 1'b0;
      o_wave_override <= '0;
    end else if (i_clk_en) begin
      o_overflow <= overflow_evt;
      o_wave_override <= (cls != timer_a_pkg::wc_none && !split) ? chan_en : '0;
    end
  end

  assign o_wave_out = wave_level;
  assign o_update_lock = update_lock;
  assign o_count_down = count_down;

  // ****************************************
  // register read
  // ****************************************
  always_comb begin
    next_rdata = '0;
    case (i_addr)
      `TA_OFS_ENABLE: next_rdata[`TA_BIT_EN] = enable;
      `TA_OFS_WAVE: begin
        next_rdata[`TA_CHEN_LSB +: NCH] = chan_en;
        next_rdata[`TA_BIT_AUTO_LOCK] = auto_lock;
        next_rdata[`TA_MODE_MSB:0] = wave_mode;
      end
      `TA_OFS_OVR: next_rdata[NCH-1:0] = ovr_val;
      `TA_OFS_SPLIT: next_rdata[`TA_BIT_SPLIT] = split;
      `TA_OFS_CLR, `TA_OFS_SET: begin
        next_rdata[`TA_BIT_LOCK] = update_lock;
        next_rdata[`TA_BIT_DIR] = count_down;
      end
      `TA_OFS_BV: next_rdata[NCH:0] = buf_valid;
      `TA_OFS_CNT_LO: next_rdata = cnt[HW-1:0];
      `TA_OFS_CNT_HI: next_rdata = cnt[CW-1:HW];
      default: next_rdata = '0;
    endcase
    for (int i = 0; i <= NCH; i++) begin
      if (hit(i_addr, `TA_OFS_BUF + 6'(2 * i))) begin
        next_rdata = buf_val[i][HW-1:0];
      end
      if (hit(i_addr, `TA_OFS_BUF + 6'(2 * i + 1))) begin
        next_rdata = buf_val[i][CW-1:HW];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_rdata <= '0;
    end else if (i_clk_en) begin
      o_rdata <= i_rd ? next_rdata : '0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_open;
    i_clk_en && auto_lock && !update_lock &&
      ((hw_update && !i_wr) || (cmd_wr && cmd == timer_a_pkg::cmd_update && !i_wdata[`TA_BIT_LOCK]));
  endsequence
  sequence s_relocked;
    update_lock && buf_valid == '0;
  endsequence

  property p_arm;
    i_clk_en && auto_lock_wr |=> update_lock;
  endproperty
  a_arm: assert property (p_arm) else $error("auto-lock write did not lock");

  property p_release;
    i_clk_en && auto_lock && update_lock && all_bv && !i_wr |=> !update_lock;
  endproperty
  a_release: assert property (p_release) else $error("lock not released");

  property p_relock;
    s_open |=> s_relocked;
  endproperty
  a_relock: assert property (p_relock) else $error("no relock after update");

  property p_manual;
    i_clk_en && !auto_lock && !i_wr |=> $stable(update_lock);
  endproperty
  a_manual: assert property (p_manual) else $error("lock moved by hardware");

  property p_single_upd;
    i_clk_en && run && wave_mode == `TA_WM_SINGLE && at_bottom && !update_lock && !i_wr
      |=> buf_valid == '0;
  endproperty
  a_single_upd: assert property (p_single_upd) else $error("single-slope update missed");

  property p_ds_both;
    i_clk_en && run && wave_mode == `TA_WM_DS_BOTH && at_bottom |=> o_overflow;
  endproperty
  a_ds_both: assert property (p_ds_both) else $error("bottom overflow missed");

  property p_normal_idle;
    i_clk_en && enable && wave_mode == `TA_WM_NORMAL |=> $stable(wave_level);
  endproperty
  a_normal_idle: assert property (p_normal_idle) else $error("normal mode waveform");

  property p_gate;
    i_clk_en && !chan_en[0] |=> !o_wave_override[0];
  endproperty
  a_gate: assert property (p_gate) else $error("override without enable");

  property p_direct;
    i_clk_en && !enable && i_wr && hit(i_addr, `TA_OFS_OVR) |=> wave_level == $past(i_wdata[NCH-1:0]);
  endproperty
  a_direct: assert property (p_direct) else $error("override level not applied");

  property p_clear;
    i_clk_en && wr_clr && i_wdata[`TA_BIT_LOCK] |=> !update_lock;
  endproperty
  a_clear: assert property (p_clear) else $error("clear view failed");

  property p_set;
    i_clk_en && wr_set && i_wdata[`TA_BIT_LOCK] && !force_reset |=> update_lock;
  endproperty
  a_set: assert property (p_set) else $error("set view failed");

  property p_cmd_zero;
    i_clk_en && i_rd && (hit(i_addr, `TA_OFS_CLR) || hit(i_addr, `TA_OFS_SET))
      |=> o_rdata[`TA_CMD_MSB:`TA_CMD_LSB] == '0 && o_rdata[`TA_BIT_LOCK] == $past(update_lock);
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command readback wrong");

  property p_locked;
    i_clk_en && update_lock && !i_wr |=> $stable(live[0]);
  endproperty
  a_locked: assert property (p_locked) else $error("copy while locked");

endmodule

`default_nettype wire

// ==== timer_a_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timer_a_defines.svh"

`define CHECK(what, exp, got) begin compares++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value %s expected %0h seen %0h", what, exp, got); end end

module testbench;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_clk_en = 1'b1;
  logic [5:0] i_addr = 6'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic [2:0] o_wave_out;
  logic [2:0] o_wave_override;
  logic o_overflow;
  logic o_update_lock;
  logic o_count_down;
  int err_count = 0;
  int compares = 0;

  always #20 i_ref_clk = ~i_ref_clk;

  timer_a_ctrl #(.NCH(3), .PERIOD_RESET(16'hffff)) u_dut (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_clk_en(i_clk_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_wave_out(o_wave_out),
    .o_wave_override(o_wave_override),
    .o_overflow(o_overflow),
    .o_update_lock(o_update_lock),
    .o_count_down(o_count_down)
  );

  // ****************************************
  // bus and helper tasks
  // ****************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    `CHECK("read data", exp, o_rdata)
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // bounded wait for the lock output to reach a level
  task automatic wait_lock(input logic exp, input int n);
    int i;
    #1;
    for (i = 0; i < n && o_update_lock !== exp; i++) begin
      idle(1);
    end
    if (o_update_lock !== exp) begin
      err_count++;
      $display("wrong value lock wait expected %0h seen %0h", exp, o_update_lock);
      complete_run();
    end
  endtask

  task automatic run_window(input int n, output int overflows, output int locks, output int downs);
    overflows = 0;
    locks = 0;
    downs = 0;
    repeat (n) begin
      idle(1);
      if (o_overflow === 1'b1) overflows++;
      if (o_update_lock === 1'b1) locks++;
      if (o_count_down === 1'b1) downs++;
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset_values();
    rd_chk(`TA_OFS_OVR, 8'h00);
    rd_chk(`TA_OFS_SPLIT, 8'h00);
    rd_chk(`TA_OFS_CLR, 8'h00);
    rd_chk(`TA_OFS_SET, 8'h00);
    rd_chk(6'h10, 8'h00);
    `CHECK("wave out", 3'b000, o_wave_out)
  endtask

  task automatic test_views();
    wr(`TA_OFS_SET, 8'h03);
    idle(2);
    `CHECK("lock", 1'b1, o_update_lock)
    `CHECK("direction", 1'b1, o_count_down)
    rd_chk(`TA_OFS_CLR, 8'h03);
    rd_chk(`TA_OFS_SET, 8'h03);
    wr(`TA_OFS_CLR, 8'h00);
    rd_chk(`TA_OFS_SET, 8'h03);
    wr(`TA_OFS_CLR, 8'h01);
    idle(2);
    `CHECK("direction", 1'b0, o_count_down)
    rd_chk(`TA_OFS_CLR, 8'h02);
    wr(`TA_OFS_SET, 8'h04);
    rd_chk(`TA_OFS_SET, 8'h02);
    wr(`TA_OFS_CLR, 8'h02);
    rd_chk(`TA_OFS_CLR, 8'h00);
  endtask

  task automatic test_override();
    wr(`TA_OFS_OVR, 8'h05);
    idle(2);
    `CHECK("wave out", 3'b101, o_wave_out)
    wr(`TA_OFS_OVR, 8'h02);
    idle(2);
    `CHECK("wave out", 3'b010, o_wave_out)
    rd_chk(`TA_OFS_OVR, 8'h02);
    wr(`TA_OFS_OVR, 8'h00);
    // a write with the clock enable low must be ignored
    i_clk_en <= 1'b0;
    wr(`TA_OFS_OVR, 8'h07);
    i_clk_en <= 1'b1;
    rd_chk(`TA_OFS_OVR, 8'h00);
    `CHECK("wave out", 3'b000, o_wave_out)
  endtask

  // leaves period at 7 and compare 0 at 3
  task automatic test_lock_block();
    wr(`TA_OFS_SET, 8'h02);
    wr(`TA_OFS_BUF, 8'h07);
    wr(`TA_OFS_BUF + 6'h01, 8'h00);
    rd_chk(`TA_OFS_BV, 8'h01);
    wr(`TA_OFS_SET, 8'h04);
    rd_chk(`TA_OFS_BV, 8'h01);
    wr(`TA_OFS_CLR, 8'h02);
    wr(`TA_OFS_SET, 8'h04);
    rd_chk(`TA_OFS_BV, 8'h00);
    wr(`TA_OFS_BUF + 6'h02, 8'h03);
    wr(`TA_OFS_BUF + 6'h03, 8'h00);
    rd_chk(`TA_OFS_BV, 8'h02);
    wr(`TA_OFS_SET, 8'h04);
    rd_chk(`TA_OFS_BV, 8'h00);
  endtask

  task automatic test_autolock();
    wr(`TA_OFS_WAVE, 8'h18);
    wait_lock(1'b1, 8);
    wr(`TA_OFS_BUF + 6'h02, 8'h03);
    wr(`TA_OFS_BUF + 6'h03, 8'h00);
    wait_lock(1'b0, 8);
    wr(`TA_OFS_SET, 8'h04);
    wait_lock(1'b1, 8);
    rd_chk(`TA_OFS_BV, 8'h00);
    wr(`TA_OFS_WAVE, 8'h00);
    wr(`TA_OFS_CLR, 8'h02);
    idle(2);
    `CHECK("lock", 1'b0, o_update_lock)
  endtask

  // 56 cycles hold whole periods of 8, 4 and 14 cycles
  task automatic test_modes();
    logic [2:0] modes [6] = '{`TA_WM_NORMAL, `TA_WM_FREQ, `TA_WM_SINGLE,
                              `TA_WM_DS_TOP, `TA_WM_DS_BOTH, `TA_WM_DS_BOTTOM};
    int exp_overflows [6] = '{7, 14, 7, 4, 8, 4};
    int overflows;
    int locks;
    int downs;
    for (int m = 0; m < 6; m++) begin
      wr(`TA_OFS_ENABLE, 8'h00);
      wr(`TA_OFS_SET, 8'h08);
      wr(`TA_OFS_WAVE, {5'b00010, modes[m]});
      wr(`TA_OFS_ENABLE, 8'h01);
      idle(20);
      run_window(56, overflows, locks, downs);
      `CHECK("overflow count", exp_overflows[m], overflows)
      `CHECK("lock count", 0, locks)
      `CHECK("down seen", (m > 2), (downs > 0))
      `CHECK("override", (m == 0) ? 3'b000 : 3'b001, o_wave_override)
    end
    wr(`TA_OFS_ENABLE, 8'h00);
    wr(`TA_OFS_SET, 8'h08);
    rd_chk(`TA_OFS_CNT_LO, 8'h00);
    rd_chk(`TA_OFS_CNT_HI, 8'h00);
  endtask

  task automatic test_hard_reset();
    wr(`TA_OFS_SET, 8'h02);
    wr(`TA_OFS_ENABLE, 8'h01);
    wr(`TA_OFS_SET, 8'h0c);
    idle(2);
    `CHECK("lock", 1'b1, o_update_lock)
    wr(`TA_OFS_ENABLE, 8'h00);
    wr(`TA_OFS_SET, 8'h0c);
    idle(2);
    `CHECK("lock", 1'b0, o_update_lock)
    rd_chk(`TA_OFS_WAVE, 8'h00);
  endtask

  task automatic test_split();
    int overflows;
    int locks;
    int downs;
    wr(`TA_OFS_SPLIT, 8'h01);
    rd_chk(`TA_OFS_SPLIT, 8'h01);
    wr(`TA_OFS_ENABLE, 8'h01);
    run_window(56, overflows, locks, downs);
    `CHECK("split overflow", 0, overflows)
    wr(`TA_OFS_ENABLE, 8'h00);
    wr(`TA_OFS_SPLIT, 8'h00);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    test_reset_values();
    test_views();
    test_override();
    test_lock_block();
    test_autolock();
    test_modes();
    test_hard_reset();
    test_split();
    complete_run();
  end
endmodule

`default_nettype wire

// ==== timer_a_defines.svh ====
`ifndef TIMER_A_DEFINES_SVH
`define TIMER_A_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define TA_OFS_ENABLE 6'h00
`define TA_OFS_WAVE 6'h01
`define TA_OFS_OVR 6'h02
`define TA_OFS_SPLIT 6'h03
`define TA_OFS_CLR 6'h04
`define TA_OFS_SET 6'h05
`define TA_OFS_BV 6'h06
`define TA_OFS_CNT_LO 6'h20
`define TA_OFS_CNT_HI 6'h21
`define TA_OFS_BUF 6'h36

// ****************************************
// field positions
// ****************************************
`define TA_BIT_EN 0
`define TA_BIT_SPLIT 0
`define TA_BIT_DIR 0
`define TA_BIT_LOCK 1
`define TA_CMD_LSB 2
`define TA_CMD_MSB 3
`define TA_MODE_MSB 2
`define TA_BIT_AUTO_LOCK 3
`define TA_CHEN_LSB 4

// ****************************************
// widths and codes
// ****************************************
`define TA_CNT_W 16
`define TA_WM_NORMAL 3'h0
`define TA_WM_FREQ 3'h1
`define TA_WM_SINGLE 3'h3
`define TA_WM_DS_TOP 3'h5
`define TA_WM_DS_BOTH 3'h6
`define TA_WM_DS_BOTTOM 3'h7

`endif

// ==== timer_a_pkg.sv ====
`default_nettype none
package timer_a_pkg;
  typedef enum logic [1:0] {cmd_none, cmd_update, cmd_restart, cmd_hard_reset} soft_cmd_e;
  typedef enum logic [1:0] {wc_none, wc_freq, wc_single, wc_dual} wave_class_e;
endpackage
`default_nettype wire
